// ==== rtl/btg_pkg.sv ====
// Constants, register map and types shared by the beep tone generator files.
package btg_pkg;

   localparam int unsigned REG_AW = 7;
   localparam int unsigned REG_DW = 8;
   localparam int unsigned SAMPLE_W = 16;
   localparam int unsigned DUR_W = 24;
   localparam int unsigned FIFO_DEPTH = 16;

   // Left beep control register and its fields.
   localparam logic [6:0] OFS_LEFT_BEEP = 7'h47;
   localparam logic [7:0] RST_LEFT_BEEP = 8'h00;
   localparam int unsigned BEEP_EN_BIT = 7;
   localparam int unsigned BEEP_RSVD_BIT = 6;
   localparam int unsigned BEEP_VOL_MSB = 5;

   // Duration and coefficient byte registers.
   localparam logic [6:0] OFS_DUR_HIGH = 7'h49;
   localparam logic [6:0] OFS_DUR_MIDDLE = 7'h4a;
   localparam logic [6:0] OFS_DUR_LOW = 7'h4b;
   localparam logic [6:0] OFS_SIN_HIGH = 7'h4c;
   localparam logic [6:0] OFS_SIN_LOW = 7'h4d;
   localparam logic [6:0] OFS_COS_HIGH = 7'h4e;
   localparam logic [6:0] OFS_COS_LOW = 7'h4f;

   localparam logic [7:0] RST_DUR_HIGH = 8'h00;
   localparam logic [7:0] RST_DUR_MIDDLE = 8'h00;
   localparam logic [7:0] RST_DUR_LOW = 8'hee;
   localparam logic [7:0] RST_SIN_HIGH = 8'h10;
   localparam logic [7:0] RST_SIN_LOW = 8'hd8;
   localparam logic [7:0] RST_COS_HIGH = 8'h7e;
   localparam logic [7:0] RST_COS_LOW = 8'he3;

   // Index of each byte in the configuration array.
   localparam int unsigned NUM_CFG = 7;
   localparam int unsigned IDX_DUR_HIGH = 0;
   localparam int unsigned IDX_DUR_MIDDLE = 1;
   localparam int unsigned IDX_DUR_LOW = 2;
   localparam int unsigned IDX_SIN_HIGH = 3;
   localparam int unsigned IDX_SIN_LOW = 4;
   localparam int unsigned IDX_COS_HIGH = 5;
   localparam int unsigned IDX_COS_LOW = 6;

   localparam logic [6:0] CFG_OFS [NUM_CFG] = '{OFS_DUR_HIGH, OFS_DUR_MIDDLE, OFS_DUR_LOW,
      OFS_SIN_HIGH, OFS_SIN_LOW, OFS_COS_HIGH, OFS_COS_LOW};
   localparam logic [7:0] CFG_RST [NUM_CFG] = '{RST_DUR_HIGH, RST_DUR_MIDDLE, RST_DUR_LOW,
      RST_SIN_HIGH, RST_SIN_LOW, RST_COS_HIGH, RST_COS_LOW};

   // Coefficients are signed Q1.15; the oscillator starts from this cosine amplitude.
   localparam int unsigned COEF_FRAC = 15;
   localparam logic [15:0] TONE_AMP_DEFAULT = 16'h4000;

   typedef enum logic [0:0] {ST_IDLE, ST_PUSH} btg_state_t;

endpackage

// ==== rtl/btg_stream_if.sv ====
// Valid/ready sample stream between the generator and its output FIFO.
`timescale 1ns/10ps
interface btg_stream_if #(parameter int WIDTH = 16) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/btg_fifo.sv ====
// Synchronous FIFO with parameterised width and depth and valid/ready on both sides.
`timescale 1ns/10ps
module btg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   btg_stream_if.snk wr_if,
   btg_stream_if.src rd_if
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;

   wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire empty = (wp_q == rp_q);
   wire do_wr = wr_if.valid && !full;
   wire do_rd = rd_if.ready && !empty;

   assign wr_if.ready = !full;
   assign rd_if.valid = !empty;
   assign rd_if.data = mem_q[rp_q[AW-1:0]];

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (do_wr) wp_q <= wp_q + {{AW{1'b0}}, 1'b1};
         if (do_rd) rp_q <= rp_q + {{AW{1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk_in) begin
      if (do_wr) mem_q[wp_q[AW-1:0]] <= wr_if.data;
   end

   AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_in) disable iff (!rstn_in)
      full && !do_rd |=> $stable(wp_q))
      else $error("FIFO write pointer moved while full.");

endmodule

// ==== rtl/btg_tone_gen.sv ====
// Beep tone generator: coefficient and duration registers, sine oscillator and sample FIFO.
`timescale 1ns/10ps
module btg_tone_gen
   import btg_pkg::*;
#(
   parameter int FIFO_WORDS = FIFO_DEPTH,
   parameter logic [15:0] TONE_AMP = TONE_AMP_DEFAULT
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [REG_AW-1:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [REG_DW-1:0] reg_wdata_in,
   output logic [REG_DW-1:0] reg_rdata_out,
   input wire logic tone_processing_mode_in,
   input wire logic sample_strobe_in,
   output logic beep_active_out,
   output logic tone_valid_out,
   output logic [SAMPLE_W-1:0] tone_data_out,
   input wire logic tone_ready_in
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register file.

   logic [7:0] cfg_q [NUM_CFG];
   logic [NUM_CFG-1:0] cfg_hit;
   logic [7:0] cfg_rd_term [NUM_CFG];
   logic en_q;
   logic en_d;
   logic rsvd_q;
   logic [BEEP_VOL_MSB:0] vol_q;
   logic [REG_DW-1:0] rd_mux;

   wire left_hit = (reg_addr_in == OFS_LEFT_BEEP);
   wire left_wr = reg_wr_in && left_hit;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
         assign cfg_hit[gi] = (reg_addr_in == CFG_OFS[gi]);
         assign cfg_rd_term[gi] = cfg_hit[gi] ? cfg_q[gi] : 8'h00;
         always_ff @(posedge clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               cfg_q[gi] <= CFG_RST[gi];
            end else if (reg_wr_in && cfg_hit[gi]) begin
               cfg_q[gi] <= reg_wdata_in;
            end
         end
      end
   endgenerate

   // Duration and coefficients are assembled from their byte registers.
   wire [DUR_W-1:0] dur_count = {
      cfg_q[IDX_DUR_HIGH],
      cfg_q[IDX_DUR_MIDDLE],
      cfg_q[IDX_DUR_LOW]
   };
   wire signed [15:0] coef_sin = {
      cfg_q[IDX_SIN_HIGH],
      cfg_q[IDX_SIN_LOW]
   };
   wire signed [15:0] coef_cos = {
      cfg_q[IDX_COS_HIGH],
      cfg_q[IDX_COS_LOW]
   };

   // Unmapped addresses read as zero.
   always_comb begin
      rd_mux = left_hit ? {en_q, rsvd_q, vol_q} : 8'h00;
      for (int i = 0; i < NUM_CFG; i++) begin
         rd_mux = rd_mux | cfg_rd_term[i];
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         reg_rdata_out <= rd_mux;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rsvd_q <= RST_LEFT_BEEP[BEEP_RSVD_BIT];
         vol_q <= RST_LEFT_BEEP[BEEP_VOL_MSB:0];
      end else if (left_wr) begin
         rsvd_q <= reg_wdata_in[BEEP_RSVD_BIT];
         vol_q <= reg_wdata_in[BEEP_VOL_MSB:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Oscillator and duration counter.

   btg_state_t state_q;
   btg_state_t state_d;
   logic [DUR_W-1:0] count_q;
   logic signed [15:0] sin_q;
   logic signed [15:0] cos_q;

   btg_stream_if #(.WIDTH(SAMPLE_W)) push_if ();
   btg_stream_if #(.WIDTH(SAMPLE_W)) pop_if ();

   wire run = en_q && tone_processing_mode_in;
   wire start_wr = left_wr && reg_wdata_in[BEEP_EN_BIT] && (dur_count != '0);
   wire push_fire = push_if.valid && push_if.ready;
   wire last_sample = push_fire && (count_q == {{(DUR_W-1){1'b0}}, 1'b1});

   // The FIFO's ready stalls the oscillator, so a full FIFO holds the current sample.
   assign push_if.valid = (state_q == ST_PUSH) && run;
   assign push_if.data = sin_q;

   // One step of the rotation: sin' = s*c + z*sn, cos' = z*c - s*sn.
   wire signed [31:0] p_sc = sin_q * coef_cos;
   wire signed [31:0] p_zs = cos_q * coef_sin;
   wire signed [31:0] p_zc = cos_q * coef_cos;
   wire signed [31:0] p_ss = sin_q * coef_sin;
   wire [32:0] sin_acc = {p_sc[31], p_sc} + {p_zs[31], p_zs};
   wire [32:0] cos_acc = {p_zc[31], p_zc} - {p_ss[31], p_ss};
   wire [15:0] sin_next = sin_acc[COEF_FRAC+15:COEF_FRAC];
   wire [15:0] cos_next = cos_acc[COEF_FRAC+15:COEF_FRAC];

   // A software write to the control register wins over the self-clear in the same cycle.
   always_comb begin
      en_d = en_q;
      if (left_wr) begin
         en_d = start_wr;
      end else if (last_sample) begin
         en_d = 1'b0;
      end
   end

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (run && sample_strobe_in && !left_wr) state_d = ST_PUSH;
         end
         ST_PUSH: begin
            if (push_fire || !run || left_wr) state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         en_q <= RST_LEFT_BEEP[BEEP_EN_BIT];
         state_q <= ST_IDLE;
      end else begin
         en_q <= en_d;
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_q <= '0;
         sin_q <= '0;
         cos_q <= '0;
      end else if (start_wr) begin
         count_q <= dur_count;
         sin_q <= '0;
         cos_q <= TONE_AMP;
      end else if (push_fire) begin
         count_q <= count_q - {{(DUR_W-1){1'b0}}, 1'b1};
         sin_q <= sin_next;
         cos_q <= cos_next;
      end
   end

   assign beep_active_out = en_q;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Output FIFO.

   btg_fifo #(
      .WIDTH(SAMPLE_W),
      .DEPTH(FIFO_WORDS)
   ) u_fifo (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .wr_if(push_if),
      .rd_if(pop_if)
   );

   assign tone_valid_out = pop_if.valid;
   assign tone_data_out = pop_if.data;
   assign pop_if.ready = tone_ready_in;

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   sequence s_start;
      left_wr && reg_wdata_in[BEEP_EN_BIT] && (dur_count != '0);
   endsequence

   sequence s_fresh_osc;
      en_q && (sin_q == 16'h0000) && (cos_q == TONE_AMP) && (count_q == $past(dur_count));
   endsequence

   sequence s_stop;
      left_wr && !reg_wdata_in[BEEP_EN_BIT];
   endsequence

   AST_DUR_HIGH_HOLD: assert property (
      !(reg_wr_in && cfg_hit[IDX_DUR_HIGH]) |=> $stable(cfg_q[IDX_DUR_HIGH]))
      else $error("Duration high byte changed without a write.");

   AST_DUR_MIDDLE_READ: assert property (
      reg_rd_in && (reg_addr_in == OFS_DUR_MIDDLE) && !reg_wr_in
      |=> reg_rdata_out == $past(dur_count[15:8]))
      else $error("Duration middle byte read back wrong.");

   AST_DUR_LOW_WRITE: assert property (
      reg_wr_in && (reg_addr_in == OFS_DUR_LOW) |=> dur_count[7:0] == $past(reg_wdata_in))
      else $error("Duration low byte did not take the written value.");

   AST_SIN_HIGH_READ: assert property (
      reg_rd_in && (reg_addr_in == OFS_SIN_HIGH) && !reg_wr_in
      |=> reg_rdata_out == $past(coef_sin[15:8]))
      else $error("Sine high byte read back wrong.");

   AST_SIN_LOW_WRITE: assert property (
      reg_wr_in && (reg_addr_in == OFS_SIN_LOW) ##1 reg_rd_in && (reg_addr_in == OFS_SIN_LOW)
      && !reg_wr_in |=> reg_rdata_out == $past(reg_wdata_in, 2))
      else $error("Sine low byte write did not read back.");

   AST_COS_HIGH_READ: assert property (
      reg_rd_in && (reg_addr_in == OFS_COS_HIGH) && !reg_wr_in
      |=> reg_rdata_out == $past(coef_cos[15:8]))
      else $error("Cosine high byte read back wrong.");

   AST_COS_LOW_WRITE: assert property (
      reg_wr_in && (reg_addr_in == OFS_COS_LOW) |=> coef_cos[7:0] == $past(reg_wdata_in))
      else $error("Cosine low byte did not take the written value.");

   AST_SELF_CLEAR: assert property (
      last_sample && !left_wr |=> !en_q && !push_if.valid)
      else $error("Enable did not clear after the last sample.");

   AST_COUNT_STEP: assert property (
      push_fire && !start_wr |=> count_q == $past(count_q) - 24'h000001)
      else $error("Sample counter did not step by one per sample.");

   AST_ZERO_DURATION: assert property (
      left_wr && (dur_count == '0) |=> !en_q)
      else $error("Enable set with a zero duration.");

   AST_MODE_GATE: assert property (
      !tone_processing_mode_in |-> !push_if.valid)
      else $error("Sample pushed outside the tone processing mode.");

   AST_START_OSC: assert property (
      s_start |=> s_fresh_osc)
      else $error("Oscillator did not restart on enable.");

   AST_ONE_STEP: assert property (
      push_fire && !start_wr ##1 !start_wr
      |-> !push_if.valid ##1 (sin_q == $past(sin_next, 2)))
      else $error("Oscillator stepped more than once per sample.");

   AST_DUR_HIGH_WRITE: assert property (
      reg_wr_in && cfg_hit[IDX_DUR_HIGH] |=> dur_count[23:16] == $past(reg_wdata_in))
      else $error("Duration high byte did not take the written value.");

   AST_DUR_MIDDLE_WRITE: assert property (
      reg_wr_in && cfg_hit[IDX_DUR_MIDDLE] |=> dur_count[15:8] == $past(reg_wdata_in))
      else $error("Duration middle byte did not take the written value.");

   AST_SIN_HIGH_WRITE: assert property (
      reg_wr_in && cfg_hit[IDX_SIN_HIGH] |=> coef_sin[15:8] == $past(reg_wdata_in))
      else $error("Sine high byte did not take the written value.");

   AST_COS_HIGH_WRITE: assert property (
      reg_wr_in && cfg_hit[IDX_COS_HIGH] |=> coef_cos[15:8] == $past(reg_wdata_in))
      else $error("Cosine high byte did not take the written value.");

   // A stop write must silence the stream at once, even with samples still due.
   AST_STOP_WRITE: assert property (
      s_stop |=> !en_q && !push_if.valid)
      else $error("Enable stayed set after a stop write.");

   // While the mode is off the counter and the oscillator must not move, except when a start write reloads them.
   AST_MODE_FREEZE: assert property (
      !tone_processing_mode_in && !start_wr |=> $stable(count_q) && $stable(sin_q))
      else $error("Generator state moved outside the tone processing mode.");

   AST_COS_STEP: assert property (
      push_fire && !start_wr |=> cos_q == $past(cos_next))
      else $error("Cosine state did not take the recurrence value.");

endmodule

// ==== testbench/btg_dac_model.sv ====
// Playback datapath model: issues sample strobes and collects tone samples from the FIFO.
`timescale 1ns/10ps
module btg_dac_model
   import btg_pkg::*;
#(
   parameter int PERIOD = 8
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic run_in,
   input wire logic stall_in,
   output logic sample_strobe_out,
   input wire logic tone_valid_in,
   input wire logic [SAMPLE_W-1:0] tone_data_in,
   output logic tone_ready_out
);
   int div_q;
   logic [SAMPLE_W-1:0] got [$];

   // A stalled datapath refuses samples so the FIFO backs up.
   assign tone_ready_out = !stall_in;
   assign sample_strobe_out = run_in && (div_q == 0);

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_q <= 0;
      end else begin
         div_q <= (div_q == PERIOD - 1) ? 0 : div_q + 1;
         if (tone_valid_in && tone_ready_out) begin
            got.push_back(tone_data_in);
         end
      end
   end
endmodule

// ==== testbench/btg_tone_gen_tb.sv ====
// Self-checking testbench for the beep tone generator.
`timescale 1ns/10ps
module btg_tone_gen_tb;
   import btg_pkg::*;

   logic clk_in = 1'b0;
   logic rstn_in = 1'b0;
   logic [REG_AW-1:0] addr = '0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [REG_DW-1:0] wdata = '0;
   logic [REG_DW-1:0] rdata;
   logic mode = 1'b1;
   logic run = 1'b1;
   logic stall = 1'b0;
   logic strobe, active, valid, ready;
   logic [SAMPLE_W-1:0] data;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;

   btg_tone_gen uut (.clk_in(clk_in), .rstn_in(rstn_in), .reg_addr_in(addr), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .tone_processing_mode_in(mode), .sample_strobe_in(strobe), .beep_active_out(active),
      .tone_valid_out(valid), .tone_data_out(data), .tone_ready_in(ready));

   btg_dac_model dac (.clk_in(clk_in), .rstn_in(rstn_in), .run_in(run), .stall_in(stall),
      .sample_strobe_out(strobe), .tone_valid_in(valid), .tone_data_in(data),
      .tone_ready_out(ready));

   initial begin
      forever #25 clk_in = ~clk_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      if (fail_count == 0 && tests_run > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // A hang is cut short well beyond the longest expected sequence.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #2 wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk_in);
      #2 wr = 1'b0;
   endtask

   task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_in);
      #2 rd = 1'b1;
      addr = a;
      @(posedge clk_in);
      #2 rd = 1'b0;
      d = rdata;
   endtask

   // Write and read the same register on two consecutive edges.
   task automatic reg_write_read(input logic [6:0] a, input logic [7:0] wd,
      output logic [7:0] rd_d);
      @(posedge clk_in);
      #2 wr = 1'b1;
      addr = a;
      wdata = wd;
      @(posedge clk_in);
      #2 wr = 1'b0;
      rd = 1'b1;
      @(posedge clk_in);
      #2 rd = 1'b0;
      rd_d = rdata;
   endtask

   task automatic wait_idle();
      for (int i = 0; i < 2000 && active !== 1'b0; i++) begin
         @(posedge clk_in);
      end
      repeat (4) @(posedge clk_in);
      #2;
   endtask

   task automatic set_tone(input logic [23:0] dur, input logic [15:0] sn, input logic [15:0] cs);
      reg_write(OFS_DUR_HIGH, dur[23:16]);
      reg_write(OFS_DUR_MIDDLE, dur[15:8]);
      reg_write(OFS_DUR_LOW, dur[7:0]);
      reg_write(OFS_SIN_HIGH, sn[15:8]);
      reg_write(OFS_SIN_LOW, sn[7:0]);
      reg_write(OFS_COS_HIGH, cs[15:8]);
      reg_write(OFS_COS_LOW, cs[7:0]);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset_and_rw();
      logic [7:0] d;
      for (int i = 0; i < NUM_CFG; i++) begin
         reg_read(CFG_OFS[i], d);
         check(d, CFG_RST[i]);
      end
      reg_read(OFS_LEFT_BEEP, d);
      check(d, RST_LEFT_BEEP);
      reg_write(7'h50, 8'h5a);
      reg_read(7'h50, d);
      check(d, 8'h00);
      for (int i = 0; i < NUM_CFG; i++) begin
         reg_write(CFG_OFS[i], 8'ha5 ^ 8'(i));
      end
      for (int i = 0; i < NUM_CFG; i++) begin
         reg_read(CFG_OFS[i], d);
         check(d, 8'ha5 ^ 8'(i));
      end
   endtask

   task automatic test_tone_run();
      logic signed [15:0] s, z, ns;
      logic signed [31:0] acc;
      logic [7:0] d;
      int base;
      set_tone(24'h000003, 16'h2000, 16'h7000);
      base = dac.got.size();
      reg_write(OFS_LEFT_BEEP, 8'h80);
      check(active, 1'b1);
      wait_idle();
      check(16'(dac.got.size() - base), 16'd3);
      reg_read(OFS_LEFT_BEEP, d);
      check(d, 8'h00);
      s = 16'sh0000;
      z = TONE_AMP_DEFAULT;
      for (int i = 0; i < 3; i++) begin
         check(dac.got[base + i], s);
         acc = s * 16'sh7000 + z * 16'sh2000;
         ns = acc[30:15];
         acc = z * 16'sh7000 - s * 16'sh2000;
         z = acc[30:15];
         s = ns;
      end
   endtask

   task automatic test_mode_gate();
      int base;
      set_tone(24'h000002, 16'h2000, 16'h7000);
      mode = 1'b0;
      base = dac.got.size();
      reg_write(OFS_LEFT_BEEP, 8'h80);
      repeat (60) @(posedge clk_in);
      #2;
      check(16'(dac.got.size() - base), 16'd0);
      check(active, 1'b1);
      mode = 1'b1;
      wait_idle();
      check(16'(dac.got.size() - base), 16'd2);
   endtask

   task automatic test_fifo_full();
      int base;
      set_tone(24'h000014, 16'h2000, 16'h7000);
      stall = 1'b1;
      base = dac.got.size();
      reg_write(OFS_LEFT_BEEP, 8'h80);
      repeat (250) @(posedge clk_in);
      #2;
      check(valid, 1'b1);
      check(active, 1'b1);
      check(16'(dac.got.size() - base), 16'd0);
      stall = 1'b0;
      wait_idle();
      check(16'(dac.got.size() - base), 16'd20);
      check(valid, 1'b0);
   endtask

   task automatic test_stop_and_zero();
      logic [7:0] d;
      int n;
      set_tone(24'h000000, 16'h2000, 16'h7000);
      reg_write(OFS_LEFT_BEEP, 8'h80);
      check(active, 1'b0);
      reg_write(OFS_DUR_LOW, 8'h40);
      reg_write(OFS_LEFT_BEEP, 8'h80);
      check(active, 1'b1);
      repeat (20) @(posedge clk_in);
      reg_write(OFS_LEFT_BEEP, 8'h00);
      check(active, 1'b0);
      wait_idle();
      n = dac.got.size();
      repeat (40) @(posedge clk_in);
      #2;
      check(16'(dac.got.size()), 16'(n));
      reg_write_read(OFS_SIN_LOW, 8'h3c, d);
      check(d, 8'h3c);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk_in);
      #2 rstn_in = 1'b1;
      test_reset_and_rw();
      test_tone_run();
      test_mode_gate();
      test_fifo_full();
      test_stop_and_zero();
      stop_test();
   end
endmodule
